// >>> include/pssd_defines.vh
/*
  Constants for the packed shift/subtract/interleave decoder: opcode bytes,
  field positions and latencies. Assumes plain Verilog-2005 includers.
*/
`ifndef PSSD_DEFINES_VH
`define PSSD_DEFINES_VH

// ****************************************
// Encoding bytes
// ****************************************
`define PSSD_ESCAPE        8'h0f
`define PSSD_SHI_WORD      8'h71
`define PSSD_SHI_DWORD     8'h72
`define PSSD_SHI_QWORD     8'h73
`define PSSD_SLL_WORD      8'hf1
`define PSSD_SLL_DWORD     8'hf2
`define PSSD_SLL_QWORD     8'hf3
`define PSSD_SRA_WORD      8'he1
`define PSSD_SRA_DWORD     8'he2
`define PSSD_SRL_WORD      8'hd1
`define PSSD_SRL_DWORD     8'hd2
`define PSSD_SRL_QWORD     8'hd3
`define PSSD_SUB_BYTE      8'hf8
`define PSSD_SUB_WORD      8'hf9
`define PSSD_SUB_DWORD     8'hfa
`define PSSD_SSUB_BYTE     8'he8
`define PSSD_SSUB_WORD     8'he9
`define PSSD_USUB_BYTE     8'hd8
`define PSSD_USUB_WORD     8'hd9
`define PSSD_IHI_BYTE      8'h68
`define PSSD_IHI_WORD      8'h69
`define PSSD_IHI_DWORD     8'h6a
`define PSSD_ILO_BYTE      8'h60
`define PSSD_ILO_WORD      8'h61
`define PSSD_ILO_DWORD     8'h62
`define PSSD_XOR           8'hef

// ****************************************
// Mod/reg/rm fields
// ****************************************
`define PSSD_MOD_HI        7
`define PSSD_MOD_LO        6
`define PSSD_REG_HI        5
`define PSSD_REG_LO        3
`define PSSD_RM_HI         2
`define PSSD_RM_LO         0
`define PSSD_MOD_REGREG    2'h3
`define PSSD_REG_SLL       3'h6
`define PSSD_REG_SRA       3'h4
`define PSSD_REG_SRL       3'h2

// ****************************************
// Operation codes and widths
// ****************************************
`define PSSD_OP_SLL        3'h0
`define PSSD_OP_SRA        3'h1
`define PSSD_OP_SRL        3'h2
`define PSSD_OP_SUB        3'h3
`define PSSD_OP_SSUB       3'h4
`define PSSD_OP_USUB       3'h5
`define PSSD_OP_IHI        3'h6
`define PSSD_OP_ILO        3'h7
`define PSSD_OP_XOR        3'h3
`define PSSD_SZ_BYTE       2'h0
`define PSSD_SZ_WORD       2'h1
`define PSSD_SZ_DWORD      2'h2
`define PSSD_SZ_QWORD      2'h3
`define PSSD_MEM_64        1'b0
`define PSSD_MEM_32        1'b1

// ****************************************
// Timing
// ****************************************
`define PSSD_EXEC_LAT      2
`define PSSD_NOP_LAT       2
`define PSSD_NOP_SLOTS     3
`define PSSD_DEP_PAD       2

`endif

// >>> src/pssd_lat_track.v
/*
  Countdown of one issued operation's execute latency, with separate
  load/store wait added on top of it by freezing the count. Assumes a single clock domain.
*/
`timescale 1ns/1ns
`include "pssd_defines.vh"

module pssd_lat_track #(
  parameter CNT_W = 4
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_b,
  // Control
  input  wire             start,
  input  wire [CNT_W-1:0] lat,
  input  wire             lsu_wait,
  // Status
  output reg              busy,
  output reg              done
);

  reg [CNT_W-1:0] count;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= {CNT_W{1'b0}};
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= lat;
        busy  <= 1'b1;
      end else if (busy && !lsu_wait) begin
        // Load/store time freezes the count, so it adds on top
        if (count == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // pssd_lat_track

// >>> src/pssd_decode.v
/*
  Decoder and dispatcher for the packed shift, subtract, saturating
  subtract, interleave and exclusive-or group. Assumes one instruction per
  cycle from fetch, with escape, opcode and mod/reg/rm bytes presented
  together, and that the load/store unit signals when memory data is late.
*/
`timescale 1ns/1ns
`include "pssd_defines.vh"

// Overview of operation
// - The integer register number comes from bits 2..0 of the mod/reg/rm byte.
// - Latency covers execution only; load/store access time adds on top.
// - Memory forms also issue an internal nop of two cycles with no dependencies.
// - Up to two internal nops can run per cycle on any of three resources.
// - Immediate shifts decode from 0f then 71/72/73 for word/dword/qword.
// - Immediate shift kind by reg field: 110 left logical, 100 right arith, 010 right logical.
// - Count shifts decode as f1-f3 left, e1-e2 right arith, d1-d3 right logical.
// - Subtract decodes f8-fa wrapping, e8-e9 signed and d8-d9 unsigned saturating.
// - Interleave high is 68-6a, low is 60-62, and low forms read 32-bit memory.
// - Exclusive-or decodes from 0f ef in register and memory forms.
// - All use the single-op path, issue to add or multiply pipe, latency 2.
// - Mod 11 selects register form, any other mod a memory form (undefined for immediate shifts), 32-bit for interleave low, else 64-bit.
module pssd_decode #(
  parameter LAT_W = 4
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // Instruction stream
  input  wire       insn_valid,
  input  wire [7:0] insn_prefix,
  input  wire [7:0] insn_opcode,
  input  wire [7:0] insn_modrm,
  // Pipe and load/store status
  input  wire       mul_pipe_busy,
  input  wire       lsu_wait,
  // Dispatch
  output reg        issue_valid,
  output reg        issue_add_pipe,
  output reg        issue_mul_pipe,
  output reg        single_op_decode_path,
  output reg  [2:0] issue_op,
  output reg  [1:0] issue_size,
  output reg        issue_xor,
  output reg        issue_mem,
  output reg        issue_mem32,
  output reg  [2:0] issue_dst,
  output reg  [2:0] issue_src,
  output reg  [LAT_W-1:0] issue_latency,
  output reg        lsu_request,
  output reg        undefined_op,
  // Internal nops
  output reg  [1:0] nop_in_flight,
  // Completion
  output wire       exec_done
);

  // ****************************************
  // Decode
  // ****************************************
  localparam [LAT_W-1:0] EXEC_LAT = `PSSD_EXEC_LAT;

  wire [1:0] mod_f = insn_modrm[`PSSD_MOD_HI:`PSSD_MOD_LO];
  wire [2:0] reg_f = insn_modrm[`PSSD_REG_HI:`PSSD_REG_LO];
  wire [2:0] rm_f  = insn_modrm[`PSSD_RM_HI:`PSSD_RM_LO];
  wire       is_reg_form = (mod_f == `PSSD_MOD_REGREG);

  reg       hit;
  reg       bad;
  reg       x_xor;
  reg       x_m32;
  reg [2:0] x_op;
  reg [1:0] x_sz;

  always @* begin
    hit   = 1'b1;
    bad   = 1'b0;
    x_xor = 1'b0;
    x_m32 = `PSSD_MEM_64;
    x_op  = `PSSD_OP_SLL;
    x_sz  = `PSSD_SZ_WORD;
    case (insn_opcode)
      `PSSD_SHI_WORD, `PSSD_SHI_DWORD, `PSSD_SHI_QWORD: begin
        x_sz = (insn_opcode == `PSSD_SHI_WORD)  ? `PSSD_SZ_WORD :
               (insn_opcode == `PSSD_SHI_DWORD) ? `PSSD_SZ_DWORD : `PSSD_SZ_QWORD;
        case (reg_f)
          `PSSD_REG_SLL: x_op = `PSSD_OP_SLL;
          `PSSD_REG_SRA: x_op = `PSSD_OP_SRA;
          `PSSD_REG_SRL: x_op = `PSSD_OP_SRL;
          default:       bad  = 1'b1;
        endcase
        // No quadword arithmetic right form exists
        if (reg_f == `PSSD_REG_SRA && x_sz == `PSSD_SZ_QWORD) bad = 1'b1;
        // Immediate forms are register-only
        if (!is_reg_form) bad = 1'b1;
      end
      `PSSD_SLL_WORD:  begin x_op = `PSSD_OP_SLL;  x_sz = `PSSD_SZ_WORD;  end
      `PSSD_SLL_DWORD: begin x_op = `PSSD_OP_SLL;  x_sz = `PSSD_SZ_DWORD; end
      `PSSD_SLL_QWORD: begin x_op = `PSSD_OP_SLL;  x_sz = `PSSD_SZ_QWORD; end
      `PSSD_SRA_WORD:  begin x_op = `PSSD_OP_SRA;  x_sz = `PSSD_SZ_WORD;  end
      `PSSD_SRA_DWORD: begin x_op = `PSSD_OP_SRA;  x_sz = `PSSD_SZ_DWORD; end
      `PSSD_SRL_WORD:  begin x_op = `PSSD_OP_SRL;  x_sz = `PSSD_SZ_WORD;  end
      `PSSD_SRL_DWORD: begin x_op = `PSSD_OP_SRL;  x_sz = `PSSD_SZ_DWORD; end
      `PSSD_SRL_QWORD: begin x_op = `PSSD_OP_SRL;  x_sz = `PSSD_SZ_QWORD; end
      `PSSD_SUB_BYTE:  begin x_op = `PSSD_OP_SUB;  x_sz = `PSSD_SZ_BYTE;  end
      `PSSD_SUB_WORD:  begin x_op = `PSSD_OP_SUB;  x_sz = `PSSD_SZ_WORD;  end
      `PSSD_SUB_DWORD: begin x_op = `PSSD_OP_SUB;  x_sz = `PSSD_SZ_DWORD; end
      `PSSD_SSUB_BYTE: begin x_op = `PSSD_OP_SSUB; x_sz = `PSSD_SZ_BYTE;  end
      `PSSD_SSUB_WORD: begin x_op = `PSSD_OP_SSUB; x_sz = `PSSD_SZ_WORD;  end
      `PSSD_USUB_BYTE: begin x_op = `PSSD_OP_USUB; x_sz = `PSSD_SZ_BYTE;  end
      `PSSD_USUB_WORD: begin x_op = `PSSD_OP_USUB; x_sz = `PSSD_SZ_WORD;  end
      `PSSD_IHI_BYTE:  begin x_op = `PSSD_OP_IHI;  x_sz = `PSSD_SZ_BYTE;  end
      `PSSD_IHI_WORD:  begin x_op = `PSSD_OP_IHI;  x_sz = `PSSD_SZ_WORD;  end
      `PSSD_IHI_DWORD: begin x_op = `PSSD_OP_IHI;  x_sz = `PSSD_SZ_DWORD; end
      `PSSD_ILO_BYTE, `PSSD_ILO_WORD, `PSSD_ILO_DWORD: begin
        x_op  = `PSSD_OP_ILO;
        x_sz  = (insn_opcode == `PSSD_ILO_BYTE) ? `PSSD_SZ_BYTE :
                (insn_opcode == `PSSD_ILO_WORD) ? `PSSD_SZ_WORD : `PSSD_SZ_DWORD;
        x_m32 = `PSSD_MEM_32;
      end
      `PSSD_XOR: begin
        x_xor = 1'b1;
        x_op  = `PSSD_OP_XOR;
        x_sz  = `PSSD_SZ_QWORD;
      end
      default: hit = 1'b0;
    endcase
  end

  wire in_group  = insn_valid && (insn_prefix == `PSSD_ESCAPE) && hit;
  wire dispatch  = in_group && !bad;

  // ****************************************
  // Dispatch register
  // ****************************************
  // Multiply pipe only when add is taken by the previous issue still in flight
  wire lat_busy;
  wire add_taken = lat_busy && issue_add_pipe;
  wire pick_mul  = add_taken && !mul_pipe_busy;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      issue_valid           <= 1'b0;
      issue_add_pipe        <= 1'b0;
      issue_mul_pipe        <= 1'b0;
      single_op_decode_path <= 1'b0;
      issue_op              <= 3'h0;
      issue_size            <= 2'h0;
      issue_xor             <= 1'b0;
      issue_mem             <= 1'b0;
      issue_mem32           <= 1'b0;
      issue_dst             <= 3'h0;
      issue_src             <= 3'h0;
      issue_latency         <= {LAT_W{1'b0}};
      lsu_request           <= 1'b0;
      undefined_op          <= 1'b0;
    end else begin
      issue_valid           <= dispatch;
      undefined_op          <= in_group && bad;
      single_op_decode_path <= dispatch;
      issue_add_pipe        <= dispatch && !pick_mul;
      issue_mul_pipe        <= dispatch && pick_mul;
      issue_latency         <= dispatch ? EXEC_LAT : {LAT_W{1'b0}};
      lsu_request           <= dispatch && !is_reg_form;
      if (dispatch) begin
        issue_op    <= x_op;
        issue_size  <= x_sz;
        issue_xor   <= x_xor;
        issue_mem   <= !is_reg_form;
        issue_mem32 <= !is_reg_form && x_m32;
        issue_dst   <= reg_f;
        issue_src   <= rm_f;
        // Immediate shifts name their destination in rm
        if (insn_opcode == `PSSD_SHI_WORD || insn_opcode == `PSSD_SHI_DWORD ||
            insn_opcode == `PSSD_SHI_QWORD)
          issue_dst <= rm_f;
      end
    end
  end

  // Tracker starts with the decode edge, so completion lands two cycles
  // after the issue pulse; a registered copy would add a cycle
  // Memory wait only stalls an operation that owns a memory operand
  pssd_lat_track #(
    .CNT_W (LAT_W)
  ) u_lat (
    .clk      (clk),
    .rst_b    (rst_b),
    .start    (dispatch),
    .lat      (EXEC_LAT),
    .lsu_wait (lsu_wait && issue_mem),
    .busy     (lat_busy),
    .done     (exec_done)
  );

  // ****************************************
  // Internal nop slots
  // ****************************************
  // Each memory form spawns one nop living two cycles; three slots are
  // plenty since at most one issue a cycle arrives, so none is ever refused.
  reg [`PSSD_NOP_SLOTS-1:0] nop_age0;
  reg [`PSSD_NOP_SLOTS-1:0] nop_ptr;
  wire spawn = dispatch && !is_reg_form;

  // Round-robin slot choice spreads nops over all resources
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      nop_ptr <= {{(`PSSD_NOP_SLOTS-1){1'b0}}, 1'b1};
    else if (spawn)
      nop_ptr <= {nop_ptr[`PSSD_NOP_SLOTS-2:0], nop_ptr[`PSSD_NOP_SLOTS-1]};
  end

  genvar g;
  generate
    for (g = 0; g < `PSSD_NOP_SLOTS; g = g + 1) begin : g_nop
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
          nop_age0[g] <= 1'b0;
        else
          nop_age0[g] <= spawn && nop_ptr[g];
      end
    end
  endgenerate

  // Second cycle of a nop's life is counted from its slot
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      nop_in_flight <= 2'h0;
    else
      nop_in_flight <= {1'b0, spawn} + {1'b0, |nop_age0};
  end

endmodule // pssd_decode

// >>> verif/pssd_decode_monitor.sv
/*
  Checker for the packed shift/subtract/interleave decoder top.
  Assumes binding onto pssd_decode, one clock, reset low async.
*/
`timescale 1ns/1ns
module pssd_decode_monitor #(
  parameter LAT_W = 4
) (
  // Clock and reset
  input wire logic             clk,
  input wire logic             rst_b,
  // Instruction stream
  input wire logic             insn_valid,
  input wire logic [7:0]       insn_prefix,
  input wire logic [7:0]       insn_opcode,
  input wire logic [7:0]       insn_modrm,
  // Dispatch
  input wire logic             issue_valid,
  input wire logic             issue_add_pipe,
  input wire logic             issue_mul_pipe,
  input wire logic             single_op_decode_path,
  input wire logic [2:0]       issue_op,
  input wire logic             issue_mem,
  input wire logic             issue_mem32,
  input wire logic [2:0]       issue_src,
  input wire logic [LAT_W-1:0] issue_latency,
  input wire logic             undefined_op,
  input wire logic [1:0]       nop_in_flight,
  input wire logic             exec_done
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire       grp = insn_valid && insn_prefix == 8'h0f;
  wire [2:0] rm  = insn_modrm[2:0];
  lat_two_a: assert property (issue_valid |-> issue_latency == 2)
    else $error("latency not two");
  one_pipe_a: assert property (issue_valid |-> issue_add_pipe != issue_mul_pipe)
    else $error("pipe choice wrong");
  direct_path_a: assert property (single_op_decode_path == issue_valid)
    else $error("decode path wrong");
  reg_src_a: assert property (grp && insn_opcode == 8'hf8 && insn_modrm[7:6] == 2'h3
    |=> issue_valid && !issue_mem && issue_op == 3'h3 && issue_src == $past(rm))
    else $error("register form wrong");
  mem_nop_a: assert property (issue_valid && issue_mem |-> nop_in_flight != 2'h0)
    else $error("no internal nop");
  done_lat_a: assert property (issue_valid && !issue_mem ##1 !issue_valid ##1 !issue_valid
    |-> exec_done)
    else $error("done not after two");
  bad_imm_a: assert property (grp && insn_opcode == 8'h71 && insn_modrm[5:3] == 3'h0
    |=> undefined_op && !issue_valid)
    else $error("bad shift dispatched");
  no_esc_a: assert property (insn_valid && insn_prefix != 8'h0f |=> !issue_valid && !undefined_op)
    else $error("foreign prefix taken");
  low_mem_a: assert property (issue_mem32 |-> issue_op == 3'h7 && issue_mem)
    else $error("32-bit operand misused");
  cover property (issue_valid && issue_mem32);
  cover property (undefined_op);
  cover property (issue_valid && issue_mem ##[1:8] exec_done);
endmodule // pssd_decode_monitor

// >>> verif/pssd_pipe_model.sv
/*
  Far-side model: load/store unit delay and multiply pipe status.
  Assumes the decoder's clock and reset.
*/
`timescale 1ns/1ns
module pssd_pipe_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Control from bench and decoder
  input  wire logic       lsu_request,
  input  wire logic       mul_hold,
  input  wire logic [1:0] lsu_delay,
  // Status
  output logic            lsu_wait,
  output logic            mul_pipe_busy
);
  logic [1:0] left;
  // Memory data arrives lsu_delay cycles late
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      left <= 2'h0;
    else if (lsu_request)
      left <= lsu_delay;
    else if (left != 2'h0)
      left <= left - 2'h1;
  end
  assign lsu_wait      = left != 2'h0;
  assign mul_pipe_busy = mul_hold;
endmodule // pssd_pipe_model

// >>> verif/pssd_decode_bench.sv
/*
  Self-checking bench for pssd_decode with the pipe model.
  Assumes the decoder, its monitor and the model are compiled first.
*/
`timescale 1ns/1ns
module pssd_decode_bench;
  logic       clk = 1'b0, rst_b = 1'b0, insn_valid = 1'b0, mul_hold = 1'b0;
  logic [7:0] insn_prefix = 8'h00, insn_opcode = 8'h00, insn_modrm = 8'h00;
  logic [1:0] lsu_delay = 2'h0;
  wire        mul_pipe_busy, lsu_wait, issue_valid, issue_add_pipe, issue_mul_pipe;
  wire        single_op_decode_path, issue_xor, issue_mem, issue_mem32, lsu_request;
  wire        undefined_op, exec_done;
  wire [2:0]  issue_op, issue_dst, issue_src;
  wire [1:0]  issue_size, nop_in_flight;
  wire [3:0]  issue_latency;
  int         fails = 0, check_count = 0;
  // Opcode, op code, size code
  logic [15:0] reg_tab [22] = '{16'hf101, 16'hf202, 16'hf303, 16'he111, 16'he212, 16'hd121,
    16'hd222, 16'hd323, 16'hf830, 16'hf931, 16'hfa32, 16'he840, 16'he941, 16'hd850,
    16'hd951, 16'h6860, 16'h6961, 16'h6a62, 16'h6070, 16'h6171, 16'h6272, 16'hef33};

  pssd_decode #(.LAT_W(4)) dut_u (.*);
  pssd_pipe_model model_u (.*);
  always #10 clk = ~clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic send(input logic [7:0] p, input logic [7:0] o, input logic [7:0] m);
    @(posedge clk);
    insn_valid  <= 1'b1;
    insn_prefix <= p;
    insn_opcode <= o;
    insn_modrm  <= m;
    @(posedge clk);
    insn_valid <= 1'b0;
    #1;
  endtask
  // Counts cycles from dispatch to completion
  task automatic wait_done(input int exp);
    int n;
    n = 0;
    while (exec_done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 20) begin
      fails++;
      wrap_up();
    end else
      chk(8'(n), 8'(exp));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reg;
    for (int i = 0; i < 22; i++) begin
      send(8'h0f, reg_tab[i][15:8], 8'hd1);
      chk(issue_valid & single_op_decode_path, 1'b1);
      chk(issue_latency, 4'h2);
      chk(issue_op, reg_tab[i][6:4]);
      chk(issue_size, reg_tab[i][1:0]);
      chk(issue_xor, reg_tab[i][15:8] == 8'hef);
      chk({issue_mem, issue_dst, issue_src}, 8'h11);
    end
    wait_done(2);
    $display("t_reg done");
  endtask
  task automatic t_imm;
    logic ok;
    for (int k = 1; k < 4; k++)
      for (int r = 0; r < 8; r++) begin
        ok = r == 6 || r == 2 || (r == 4 && k != 3);
        send(8'h0f, 8'h70 + 8'(k), {2'h3, 3'(r), 3'h5});
        chk({issue_valid, undefined_op}, {ok, !ok});
        if (ok) begin
          chk(issue_op, 3'h3 - 3'(r / 2));
          chk({issue_size, issue_dst}, {2'(k), 3'h5});
        end
      end
    $display("t_imm done");
  endtask
  task automatic t_mem;
    @(posedge clk);
    lsu_delay <= 2'h2;
    send(8'h0f, 8'h60, 8'h0c);
    chk({issue_mem, issue_mem32, lsu_request}, 3'h7);
    chk(nop_in_flight != 2'h0, 1'b1);
    wait_done(4);
    chk(nop_in_flight, 2'h0);
    repeat (4) @(posedge clk);
    send(8'h0f, 8'hef, 8'h4a);
    chk({issue_xor, issue_mem, issue_mem32}, 3'h6);
    wait_done(4);
    $display("t_mem done");
  endtask
  task automatic t_refuse;
    @(posedge clk);
    mul_hold <= 1'b1;
    send(8'h0e, 8'hf8, 8'hd1);
    chk({issue_valid, undefined_op}, 2'h0);
    send(8'h0f, 8'h71, 8'h30);
    chk({issue_valid, undefined_op}, 2'h1);
    send(8'h0f, 8'hf9, 8'hc3);
    chk({issue_add_pipe, issue_mul_pipe}, 2'h2);
    $display("t_refuse done");
  endtask
  // Back-to-back issue: second op finds add busy and takes multiply
  task automatic t_pipes;
    @(posedge clk);
    mul_hold    <= 1'b0;
    insn_valid  <= 1'b1;
    insn_prefix <= 8'h0f;
    insn_opcode <= 8'hf8;
    insn_modrm  <= 8'hc1;
    @(posedge clk);
    insn_opcode <= 8'hf9;
    #1;
    chk({issue_add_pipe, issue_mul_pipe}, 2'h2);
    @(posedge clk);
    insn_valid <= 1'b0;
    #1;
    chk({issue_valid, issue_add_pipe, issue_mul_pipe}, 3'h5);
    chk(issue_size, 2'h1);
    wait_done(2);
    $display("t_pipes done");
  endtask
  // Reset in mid-flight of a memory form clears everything
  task automatic t_reset;
    lsu_delay <= 2'h3;
    send(8'h0f, 8'h62, 8'h05);
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    chk({issue_valid, issue_mem, lsu_request, nop_in_flight, exec_done}, 8'h00);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(exec_done, 1'b0);
    send(8'h0f, 8'hd8, 8'hc0);
    chk({issue_valid, issue_op}, 4'hd);
    wait_done(2);
    $display("t_reset done");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    chk(issue_valid, 1'b0);
    rst_b <= 1'b1;
    t_reg();
    t_imm();
    t_mem();
    t_refuse();
    t_pipes();
    t_reset();
    wrap_up();
  end
endmodule // pssd_decode_bench

bind pssd_decode pssd_decode_monitor #(.LAT_W(LAT_W)) mon_u (.*);
